// *** hdl/stats_pkg.sv ***
package stats_pkg;
   // Datapath widths
   localparam int WGT_W  = 24;   // Signed weight sample
   localparam int CNT_W  = 16;   // Accumulation count
   localparam int SUM_W  = 40;   // Signed running total
   localparam int SQ_W   = 64;   // Sum of squares
   localparam int VAR_W  = 80;   // n*sum(x^2) - (sum x)^2
   localparam int ROOT_W = 40;   // Square root of VAR_W
   localparam int CODE_W = 16;
   localparam int JT_W   = 8;

   // Operator clear password, 1235 decimal
   localparam logic [CODE_W-1:0] CLEAR_CODE = 16'h04D3;
   // Judging times value that disables sampling
   localparam logic [JT_W-1:0]   JT_NONE    = 8'h00;
   localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h0001;
   localparam logic [CNT_W-1:0]  CNT_TWO    = 16'h0002;
   localparam logic [6:0]        ROOT_STEPS = 7'h28;   // ROOT_W steps

   typedef enum logic [2:0] {
      st_idle, st_mean, st_root, st_gen, st_smp, st_sroot
   } calc_st_t;
endpackage

// *** hdl/seq_divider.sv ***
`timescale 1ns/10ps
`default_nettype none
// Restoring divider, one quotient bit per cycle; start restarts it
module seq_divider #(
   parameter int W = 80
) (
   input  wire logic         core_clk,
   input  wire logic         reset,
   input  wire logic         start,
   input  wire logic [W-1:0] dividend,
   input  wire logic [W-1:0] divisor,
   output var  logic         done,
   output var  logic [W-1:0] quotient
);
   localparam int CW = $clog2(W + 1);

   logic [W-1:0]  rem_ff;
   logic [W-1:0]  den_ff;
   logic [CW-1:0] cnt_ff;
   logic          busy_ff;
   wire  [W:0]    shifted = {rem_ff, quotient[W-1]};
   wire  [W:0]    diff    = shifted - {1'b0, den_ff};
   wire           fits    = ~diff[W];

   // Shift-subtract loop; a zero divisor yields all ones
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rem_ff   <= '0;
         den_ff   <= '0;
         quotient <= '0;
         cnt_ff   <= '0;
         busy_ff  <= 1'b0;
         done     <= 1'b0;
      end else if (start) begin
         rem_ff   <= '0;
         den_ff   <= divisor;
         quotient <= dividend;
         cnt_ff   <= CW'(W);
         busy_ff  <= 1'b1;
         done     <= 1'b0;
      end else begin
         done <= busy_ff && (cnt_ff == CW'(1));
         if (busy_ff) begin
            rem_ff   <= fits ? diff[W-1:0] : shifted[W-1:0];
            quotient <= {quotient[W-2:0], fits};
            cnt_ff   <= cnt_ff - CW'(1);
            busy_ff  <= (cnt_ff != CW'(1));
         end
      end
   end
endmodule // seq_divider
`default_nettype wire

// *** hdl/weighing_stats.sv ***
// Behaviour
// - Each accepted sample bumps count by one and adds weight into total.
// - Average weight equals running total divided by count.
// - General deviation: root of summed squared deviations over n.
// - Sample deviation: root of summed squared deviations over n-1.
// - With auto compensation off, sample at each judgment.
// - With auto compensation on, sample only at compensation events.
// - Judging times of zero disables all sampling.
// - Clear command with password 1235 zeroes every statistic.
// - Track maximum and minimum; output their difference as range.
// - Hold latest accepted sample, replaced by each new sample.
`timescale 1ns/10ps
`default_nettype none
module weighing_stats (
   input  wire logic                               core_clk,
   input  wire logic                               reset,
   input  wire logic signed [stats_pkg::WGT_W-1:0] sample_weight,
   input  wire logic                               judge_evt,
   input  wire logic                               comp_evt,
   input  wire logic                               afc_enable,
   input  wire logic [stats_pkg::JT_W-1:0]         judging_times,
   input  wire logic                               clear_req,
   input  wire logic [stats_pkg::CODE_W-1:0]       clear_code,
   output var  logic [stats_pkg::CNT_W-1:0]        acc_count,
   output var  logic signed [stats_pkg::SUM_W-1:0] acc_total,
   output var  logic signed [stats_pkg::SUM_W-1:0] avg_weight,
   output var  logic signed [stats_pkg::WGT_W-1:0] max_weight,
   output var  logic signed [stats_pkg::WGT_W-1:0] min_weight,
   output var  logic [stats_pkg::WGT_W:0]          range_weight,
   output var  logic signed [stats_pkg::WGT_W-1:0] latest_weight,
   output var  logic [stats_pkg::ROOT_W-1:0]       gen_sd,
   output var  logic [stats_pkg::ROOT_W-1:0]       smp_sd,
   output var  logic                               gen_err,
   output var  logic                               smp_err,
   output var  logic                               calc_busy
);
   localparam int WGT_W = stats_pkg::WGT_W;
   localparam int SUM_W = stats_pkg::SUM_W;
   localparam int VAR_W = stats_pkg::VAR_W;
   localparam int RW    = stats_pkg::ROOT_W;

   stats_pkg::calc_st_t state_ff;
   logic [stats_pkg::SQ_W-1:0] sumsq_ff;
   logic [VAR_W-1:0]           sq_op_ff;
   logic [VAR_W-1:0]           sq_res_ff;
   logic [VAR_W-1:0]           sq_bit_ff;
   logic [6:0]                 sq_cnt_ff;
   logic [RW-1:0]              root_ff;
   logic                       div_start_ff;
   logic                       div_done;
   logic [VAR_W-1:0]           div_q;

   // Sample selection and password match
   wire evt_pick   = afc_enable ? comp_evt : judge_evt;
   wire sample_hit = evt_pick && (judging_times != stats_pkg::JT_NONE);
   wire clr_hit    = clear_req && (clear_code == stats_pkg::CLEAR_CODE);
   wire take       = sample_hit && !clr_hit;
   wire first      = (acc_count == '0);

   // Accumulator next values
   wire [WGT_W-1:0] w_mag = sample_weight[WGT_W-1] ?
                            WGT_W'(-sample_weight) : sample_weight;
   wire [2*WGT_W-1:0] w_sq  = w_mag * w_mag;
   wire [stats_pkg::CNT_W-1:0] nxt_count = clr_hit ? '0 :
                            take ? acc_count + stats_pkg::CNT_ONE : acc_count;
   wire signed [SUM_W-1:0] nxt_total = acc_total + SUM_W'(sample_weight);
   wire signed [WGT_W-1:0] nxt_max = (first || sample_weight > max_weight) ?
                                     sample_weight : max_weight;
   wire signed [WGT_W-1:0] nxt_min = (first || sample_weight < min_weight) ?
                                     sample_weight : min_weight;

   // Spread term n*sum(x^2) - (sum x)^2, never negative
   wire [SUM_W-1:0] sum_mag = acc_total[SUM_W-1] ?
                              SUM_W'(-acc_total) : acc_total;
   wire [VAR_W-1:0] spread = VAR_W'(acc_count) * VAR_W'(sumsq_ff)
                           - VAR_W'(sum_mag) * VAR_W'(sum_mag);
   wire [VAR_W-1:0] n_nm1  = VAR_W'(acc_count)
                           * VAR_W'(acc_count - stats_pkg::CNT_ONE);

   // Divider operand select by phase
   wire [VAR_W-1:0] div_num = (state_ff == stats_pkg::st_mean) ?
                              VAR_W'(sum_mag) :
                              (state_ff == stats_pkg::st_gen) ?
                              VAR_W'(root_ff) : spread;
   wire [VAR_W-1:0] div_den = (state_ff == stats_pkg::st_smp) ?
                              n_nm1 : VAR_W'(acc_count);

   // Digit-by-digit square root step
   wire [VAR_W-1:0] sq_trial = sq_res_ff + sq_bit_ff;
   wire             sq_fits  = (sq_op_ff >= sq_trial);
   wire             sq_last  = (sq_cnt_ff == stats_pkg::ROOT_STEPS);
   wire             rooting  = (state_ff == stats_pkg::st_root) ||
                               (state_ff == stats_pkg::st_sroot);
   wire [VAR_W-1:0] sq_top   = {2'b01, {(VAR_W-2){1'b0}}};
   wire [VAR_W-1:0] sq_next  = sq_fits ? (sq_res_ff >> 1) + sq_bit_ff
                                        : (sq_res_ff >> 1);
   // A done pulse met by a fresh restart belongs to the old operands
   wire             div_fresh = div_done && !div_start_ff;

   seq_divider #(.W(VAR_W)) u_div (
      .core_clk (core_clk),
      .reset    (reset),
      .start    (div_start_ff),
      .dividend (div_num),
      .divisor  (div_den),
      .done     (div_done),
      .quotient (div_q)
   );

   // Running accumulators; clear beats a same-cycle sample
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         acc_count     <= '0;
         acc_total     <= '0;
         sumsq_ff      <= '0;
         max_weight    <= '0;
         min_weight    <= '0;
         latest_weight <= '0;
      end else if (clr_hit) begin
         acc_count     <= '0;
         acc_total     <= '0;
         sumsq_ff      <= '0;
         max_weight    <= '0;
         min_weight    <= '0;
         latest_weight <= '0;
      end else if (take) begin
         acc_count     <= nxt_count;
         acc_total     <= nxt_total;
         sumsq_ff      <= sumsq_ff + stats_pkg::SQ_W'(w_sq);
         max_weight    <= nxt_max;
         min_weight    <= nxt_min;
         latest_weight <= sample_weight;
      end
   end

   // Range lags max/min by one cycle; error flags follow count
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         range_weight <= '0;
         gen_err      <= 1'b1;
         smp_err      <= 1'b1;
      end else begin
         range_weight <= (WGT_W+1)'(max_weight - min_weight);
         gen_err      <= (nxt_count == '0);
         smp_err      <= (nxt_count < stats_pkg::CNT_TWO);
      end
   end

   // Calculation sequencer; a new sample restarts the chain
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_ff     <= stats_pkg::st_idle;
         div_start_ff <= 1'b0;
      end else if (clr_hit) begin
         state_ff     <= stats_pkg::st_idle;
         div_start_ff <= 1'b0;
      end else if (take) begin
         state_ff     <= stats_pkg::st_mean;
         div_start_ff <= 1'b1;
      end else begin
         div_start_ff <= 1'b0;
         unique case (state_ff)
            stats_pkg::st_idle: ;
            stats_pkg::st_mean: if (div_fresh) begin
               state_ff <= stats_pkg::st_root;
            end
            stats_pkg::st_root: if (sq_last) begin
               state_ff     <= stats_pkg::st_gen;
               div_start_ff <= 1'b1;
            end
            stats_pkg::st_gen: if (div_fresh) begin
               state_ff     <= smp_err ? stats_pkg::st_idle
                                       : stats_pkg::st_smp;
               div_start_ff <= !smp_err;
            end
            stats_pkg::st_smp: if (div_fresh) begin
               state_ff <= stats_pkg::st_sroot;
            end
            stats_pkg::st_sroot: if (sq_last) begin
               state_ff <= stats_pkg::st_idle;
            end
         endcase
      end
   end

   // Root engine; loads spread, or the n(n-1) quotient for sample SD
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sq_op_ff  <= '0;
         sq_res_ff <= '0;
         sq_bit_ff <= '0;
         sq_cnt_ff <= '0;
      end else if (!rooting) begin
         sq_op_ff  <= (state_ff == stats_pkg::st_smp) ? div_q : spread;
         sq_res_ff <= '0;
         sq_bit_ff <= sq_top;
         sq_cnt_ff <= 7'h01;
      end else begin
         sq_op_ff  <= sq_fits ? sq_op_ff - sq_trial : sq_op_ff;
         sq_res_ff <= sq_next;
         sq_bit_ff <= sq_bit_ff >> 2;
         sq_cnt_ff <= sq_cnt_ff + 7'h01;
      end
   end

   // Result registers; values stay truncated to whole weight units
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         avg_weight <= '0;
         root_ff    <= '0;
         gen_sd     <= '0;
         smp_sd     <= '0;
         calc_busy  <= 1'b0;
      end else if (clr_hit) begin
         avg_weight <= '0;
         root_ff    <= '0;
         gen_sd     <= '0;
         smp_sd     <= '0;
         calc_busy  <= 1'b0;
      end else begin
         calc_busy <= take || (state_ff != stats_pkg::st_idle &&
                      !(state_ff == stats_pkg::st_sroot && sq_last) &&
                      !(state_ff == stats_pkg::st_gen && div_fresh &&
                        smp_err));
         if (state_ff == stats_pkg::st_mean && div_fresh) begin
            avg_weight <= acc_total[SUM_W-1] ? -SUM_W'(div_q)
                                             : SUM_W'(div_q);
         end
         if (state_ff == stats_pkg::st_root && sq_last) begin
            root_ff <= RW'(sq_next);
         end
         if (state_ff == stats_pkg::st_gen && div_fresh) begin
            gen_sd <= RW'(div_q);
         end
         if (state_ff == stats_pkg::st_sroot && sq_last) begin
            smp_sd <= RW'(sq_next);
         end
      end
   end

   // Checks
   AST_COUNT_STEP: assert property (@(posedge core_clk)
      disable iff (reset)
      take |=> acc_count == $past(acc_count) + stats_pkg::CNT_ONE)
      else $error("count did not step on sample");
   AST_TOTAL_ADD: assert property (@(posedge core_clk)
      disable iff (reset)
      take |=> acc_total == $past(acc_total) + SUM_W'($past(sample_weight)))
      else $error("total did not add sample");
   AST_JUDGE_ONLY: assert property (@(posedge core_clk)
      disable iff (reset)
      !afc_enable && comp_evt && !judge_evt && !clr_hit |=> $stable(acc_count))
      else $error("compensation sampled with auto off");
   AST_COMP_ONLY: assert property (@(posedge core_clk)
      disable iff (reset)
      afc_enable && judge_evt && !comp_evt && !clr_hit |=> $stable(acc_count))
      else $error("judgment sampled with auto on");
   AST_NO_TIMES: assert property (@(posedge core_clk)
      disable iff (reset)
      judging_times == stats_pkg::JT_NONE && !clr_hit |=> $stable(acc_total))
      else $error("sample taken with zero judging times");
   AST_CLEAR: assert property (@(posedge core_clk)
      disable iff (reset)
      clr_hit |=> acc_count == '0 && acc_total == '0 && max_weight == '0 &&
                  min_weight == '0 && latest_weight == '0 && gen_err)
      else $error("clear left statistics");
   AST_RANGE: assert property (@(posedge core_clk)
      disable iff (reset)
      take ##2 !clr_hit[*1] |-> range_weight ==
         (WGT_W+1)'($past(max_weight) - $past(min_weight)))
      else $error("range wrong");
   AST_LATEST: assert property (@(posedge core_clk)
      disable iff (reset)
      take |=> latest_weight == $past(sample_weight) &&
               max_weight >= latest_weight && min_weight <= latest_weight)
      else $error("latest or extremes wrong");
   AST_ERR_FLAGS: assert property (@(posedge core_clk)
      disable iff (reset)
      acc_count == '0 |-> gen_err && smp_err)
      else $error("error flags clear at zero count");
   AST_CALC_DONE: assert property (@(posedge core_clk)
      disable iff (reset)
      take ##1 (!take && !clr_hit)[*8] |-> ##[1:400] !calc_busy)
      else $error("calculation did not finish");
   COV_SAMPLE_AFC: cover property (@(posedge core_clk) disable iff (reset)
      take && afc_enable);
   COV_SAMPLE_JUDGE: cover property (@(posedge core_clk) disable iff (reset)
      take && !afc_enable);
   COV_SMP_SD: cover property (@(posedge core_clk) disable iff (reset)
      state_ff == stats_pkg::st_sroot && sq_last);
   COV_CLEAR: cover property (@(posedge core_clk) disable iff (reset)
      clr_hit && acc_count != '0);
endmodule // weighing_stats
`default_nettype wire

// *** test/evt_source.sv ***
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the sequence logic: every judgment is followed later by a
// compensation pulse, so the unselected kind is seen and must be dropped
module evt_source #(
   parameter int COMP_DLY = 3
) (
   input  wire logic                               core_clk,
   input  wire logic                               reset,
   input  wire logic                               fire,
   input  wire logic signed [stats_pkg::WGT_W-1:0] w_in,
   output var  logic                               judge_evt,
   output var  logic                               comp_evt,
   output var  logic signed [stats_pkg::WGT_W-1:0] sample_weight
);
   logic [COMP_DLY-1:0] dly_ff;

   // Weight travels with its event so it is settled when taken
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         judge_evt     <= 1'b0;
         comp_evt      <= 1'b0;
         dly_ff        <= '0;
         sample_weight <= '0;
      end else begin
         judge_evt <= fire;
         dly_ff    <= {dly_ff[COMP_DLY-2:0], fire};
         comp_evt  <= dly_ff[COMP_DLY-1];
         if (fire) begin
            sample_weight <= w_in;
         end
      end
   end
endmodule // evt_source
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int CYC_MAX = 60000;
   logic core_clk, reset, fire, afc_enable, clear_req, judge_evt, comp_evt;
   logic signed [stats_pkg::WGT_W-1:0] w_in, sample_weight, latest_weight;
   logic signed [stats_pkg::WGT_W-1:0] max_weight, min_weight;
   logic signed [stats_pkg::SUM_W-1:0] acc_total, avg_weight;
   logic [stats_pkg::JT_W-1:0]         judging_times;
   logic [stats_pkg::CODE_W-1:0]       clear_code;
   logic [stats_pkg::CNT_W-1:0]        acc_count;
   logic [stats_pkg::WGT_W:0]          range_weight;
   logic [stats_pkg::ROOT_W-1:0]       gen_sd, smp_sd;
   logic                               gen_err, smp_err, calc_busy;
   longint n, sx, sxx, mx, mn, lw;
   int error_cnt, compares;

   evt_source src (.core_clk(core_clk), .reset(reset), .fire(fire),
      .w_in(w_in), .judge_evt(judge_evt),
      .comp_evt(comp_evt), .sample_weight(sample_weight));

   weighing_stats dut (.core_clk(core_clk), .reset(reset),
      .sample_weight(sample_weight), .judge_evt(judge_evt),
      .comp_evt(comp_evt), .afc_enable(afc_enable),
      .judging_times(judging_times), .clear_req(clear_req),
      .clear_code(clear_code), .acc_count(acc_count), .acc_total(acc_total),
      .avg_weight(avg_weight), .max_weight(max_weight),
      .min_weight(min_weight), .range_weight(range_weight),
      .latest_weight(latest_weight), .gen_sd(gen_sd), .smp_sd(smp_sd),
      .gen_err(gen_err), .smp_err(smp_err), .calc_busy(calc_busy));

   // Own root, bit by bit, independent of the divider chain
   function automatic longint isqrt(input longint v);
      longint r;
      r = 0;
      for (int b = 31; b >= 0; b--) begin
         if ((r + (64'h1 << b)) * (r + (64'h1 << b)) <= v) r += 64'h1 << b;
      end
      return r;
   endfunction

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic model_add(input longint w);
      n++;
      sx += w;
      sxx += w * w;
      lw = w;
      mx = (n == 1 || w > mx) ? w : mx;
      mn = (n == 1 || w < mn) ? w : mn;
   endtask

   task automatic model_clr;
      n = 0;
      sx = 0;
      sxx = 0;
      mx = 0;
      mn = 0;
      lw = 0;
   endtask

   // Bounded wait for the mean and deviation chain to finish
   task automatic settle;
      int i;
      repeat (8) @(posedge core_clk);
      for (i = 0; i < 1000 && calc_busy !== 1'b0; i++) @(posedge core_clk);
      cmp(calc_busy, 1'b0);
   endtask

   task automatic check_all;
      cmp(acc_count, n);
      cmp(acc_total, sx);
      cmp(latest_weight, lw);
      cmp(max_weight, mx);
      cmp(min_weight, mn);
      cmp(range_weight, mx - mn);
      cmp(gen_err, n == 0);
      cmp(smp_err, n < 2);
      if (n > 0) begin
         cmp(avg_weight, sx / n);
         cmp(gen_sd, isqrt(n * sxx - sx * sx) / n);
      end else begin
         cmp(avg_weight, 64'h0);
      end
      if (n > 1) cmp(smp_sd, isqrt((n * sxx - sx * sx) / (n * (n - 1))));
   endtask

   task automatic feed(input longint w, input bit counts);
      fire <= 1'b1;
      w_in <= w[stats_pkg::WGT_W-1:0];
      @(posedge core_clk);
      fire <= 1'b0;
      if (counts) model_add(w);
      settle();
      check_all();
   endtask

   task automatic t_series;
      longint vals[6] = '{20050, 20040, 20070, 20080, 20020, -317};
      foreach (vals[i]) feed(vals[i], 1'b1);
      $display("series test done");
   endtask

   // Judgment and compensation both pulse; only compensation counts
   task automatic t_afc;
      afc_enable <= 1'b1;
      feed(20110, 1'b1);
      feed(19980, 1'b1);
      afc_enable <= 1'b0;
      $display("compensation test done");
   endtask

   task automatic t_jt0;
      judging_times <= stats_pkg::JT_NONE;
      feed(999, 1'b0);
      judging_times <= 8'h05;
      $display("judging times test done");
   endtask

   task automatic t_b2b;
      fire <= 1'b1;
      w_in <= 24'sd300;
      @(posedge core_clk);
      w_in <= -24'sd41;
      @(posedge core_clk);
      fire <= 1'b0;
      model_add(300);
      model_add(-41);
      settle();
      check_all();
      $display("back to back test done");
   endtask

   // Wrong code is ignored; right code beats a coincident sample
   task automatic t_clear;
      clear_req  <= 1'b1;
      clear_code <= 16'h04D2;
      @(posedge core_clk);
      clear_req <= 1'b0;
      repeat (2) @(posedge core_clk);
      check_all();
      fire <= 1'b1;
      w_in <= 24'sd77;
      @(posedge core_clk);
      fire       <= 1'b0;
      clear_req  <= 1'b1;
      clear_code <= stats_pkg::CLEAR_CODE;
      @(posedge core_clk);
      clear_req <= 1'b0;
      model_clr();
      repeat (2) @(posedge core_clk);
      check_all();
      feed(-5, 1'b1);
      $display("clear test done");
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   initial begin
      repeat (CYC_MAX) @(posedge core_clk);
      error_cnt++;
      finish_test();
   end

   initial begin
      reset = 1'b1;
      fire = 1'b0;
      afc_enable = 1'b0;
      clear_req = 1'b0;
      w_in = '0;
      judging_times = 8'h05;
      clear_code = 16'h0000;
      error_cnt = 0;
      compares = 0;
      model_clr();
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      check_all();
      t_series();
      t_afc();
      t_jt0();
      t_b2b();
      t_clear();
      finish_test();
   end
endmodule // testbench
`default_nettype wire
